//--- design/compare_channel.sv
module compare_channel
  import timer_wave_pkg::*;
#(
  parameter bit CHAN_IS_A = 1'b0
)
(
  // clock, reset and enable
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // timer events
  input wire logic tick_i,
  input wire kind_t kind_i,
  input wire logic [1:0] action_i,
  input wire logic wave_mode_msb_i,
  input wire logic match_i,
  input wire logic at_top_i,
  input wire logic phase_down_i,
  // pin side
  output logic wave_o,
  output logic pin_take_o
);

  logic wave_q;
  logic pin_take_q;
  logic toggle_ok;

  // code 01 toggles in non-PWM modes; in PWM modes only channel A with msb set
  assign toggle_ok = (action_i == 2'h1) &&
                     ((kind_i == KIND_NORMAL) || (kind_i == KIND_MATCH_CLR) ||
                      (wave_mode_msb_i && CHAN_IS_A)); // R5

  // waveform register, advanced only on timer ticks
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wave_q <= 1'b0;
    end
    else if (ce_i && tick_i)
    begin
      case (kind_i)
        KIND_NORMAL, KIND_MATCH_CLR:
        begin
          if (match_i && action_i[1])
            wave_q <= action_i[0]; // R3
          else if (match_i && toggle_ok)
            wave_q <= ~wave_q; // R3
        end
        KIND_FAST:
        begin
          // the top event wins, so with codes 10 and 11 a match at top is ignored; code 01 still toggles there
          if (action_i[1] && at_top_i)
            wave_q <= ~action_i[0]; // R4 R6
          else if (action_i[1] && match_i)
            wave_q <= action_i[0]; // R4
          else if (match_i && toggle_ok)
            wave_q <= ~wave_q; // R5
        end
        KIND_DUAL:
        begin
          if (action_i[1] && match_i)
            wave_q <= phase_down_i ? ~action_i[0] : action_i[0]; // R7
          else if (match_i && toggle_ok)
            wave_q <= ~wave_q; // R5
        end
        default:
        begin
          wave_q <= wave_q;
        end
      endcase
    end
  end

  // pin takeover follows the action field; reserved codes leave the port alone
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pin_take_q <= 1'b0;
    else if (ce_i)
      pin_take_q <= (action_i == 2'h1) ? toggle_ok : (action_i != 2'h0); // R1 R5
  end

  assign wave_o = wave_q;
  assign pin_take_o = pin_take_q;

endmodule : compare_channel

//--- design/timer_wave_mode_output_control.sv
// Operation
// (R1) a nonzero channel action field hands that channel's compare output the pin.
// (R2) software sets the pin direction to output, or the waveform stays inside.
// (R3) non-PWM codes: 00 disconnect, 01 toggle, 10 clear, 11 set on match.
// (R4) fast PWM code 10 clears on match and sets at top, code 11 the reverse.
// (R5) PWM code 01 disconnects unless mode msb is set, then toggles channel A only.
// (R6) in fast PWM a match equal to top is ignored and the top action still happens.
// (R7) dual-slope code 10 clears on up-count match and sets on down-count, 11 reverse.
// (R8) two low mode bits here join two high bits in control B as one 4-bit mode.
// (R9) modes 1 to 3 are dual-slope with fixed top, reload at top, overflow at bottom.
// (R10) modes 0, 4 and 12 count to max or clear on match, reload now, overflow at max.
// (R11) modes 5 to 7, 14 and 15 are fast PWM with reload and overflow at top.
// (R12) modes 8 to 11 are dual-slope with top from capture or compare A.
// (R13) software never selects the reserved mode 13.
// (R14) the two high mode bits sit at bits 4 and 3 of control register B.
// (R15) dual-slope counting runs up from zero to top and back down to zero.
module timer_wave_mode_output_control
  import timer_wave_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // compare outputs and pin takeover
  output logic compare_out_a_o,
  output logic compare_out_b_o,
  output logic compare_out_c_o,
  output logic pin_override_a_o,
  output logic pin_override_b_o,
  output logic pin_override_c_o,
  // interrupt
  output logic irq_o
);

  logic [7:0] output_mode_ctrl_q;
  logic [7:0] timer_control_b_q;
  logic [15:0] cmp_buf_q [3];
  logic [15:0] cmp_act_q [3];
  logic [15:0] capture_value_q;
  logic [15:0] count_q;
  phase_t phase_q;
  logic [IRQ_WIDTH-1:0] irq_status_q;
  logic [IRQ_WIDTH-1:0] irq_mask_q;
  logic irq_q;
  logic awready_q, wready_q, aw_held_q, w_held_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic do_write;
  logic [3:0] wave_mode_select;
  mode_info_t mode;
  logic [15:0] top_val;
  logic tick, at_top, at_bottom, ovf_evt, reload_evt;
  logic [2:0] match;
  logic [1:0] action [3];
  logic [2:0] wave, pin_take;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // word-aligned address compare used by both channels of the bus
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_addr);
    return {a[7:2], 2'h0} == reg_addr;
  endfunction : addr_is

  function automatic logic addr_mapped(input logic [7:0] a);
    return addr_is(a, ADDR_OUTPUT_MODE_CTRL) || addr_is(a, ADDR_TIMER_CONTROL_B) ||
           addr_is(a, ADDR_COMPARE_A) || addr_is(a, ADDR_COMPARE_B) ||
           addr_is(a, ADDR_COMPARE_C) || addr_is(a, ADDR_CAPTURE) ||
           addr_is(a, ADDR_COUNTER) || addr_is(a, ADDR_IRQ_STATUS) ||
           addr_is(a, ADDR_IRQ_MASK);
  endfunction : addr_mapped

  // mode selector and its decode; mode 13 is never chosen by software
  assign wave_mode_select = {timer_control_b_q[WAVE_MODE_HIGH_LSB +: 2],
                             output_mode_ctrl_q[WAVE_MODE_LOW_LSB +: 2]}; // R8 R14
  assign mode = decode_mode(wave_mode_select); // R9 R10 R11 R12

  // top comes from a fixed value, active compare A or the capture register
  always_comb
  begin
    case (mode.top_src)
      TOP_CMP_A: top_val = cmp_act_q[0]; // R10 R11 R12
      TOP_CAPTURE: top_val = capture_value_q; // R10 R11 R12
      default: top_val = mode.fixed_top; // R9 R11
    endcase
  end

  assign tick = ce_i && timer_control_b_q[COUNT_RUN_BIT];
  assign at_top = (count_q == top_val);
  assign at_bottom = (count_q == COUNT_BOTTOM);

  // overflow and reload points taken from the mode decode
  always_comb
  begin
    case (mode.ovf)
      PT_TOP: ovf_evt = tick && at_top; // R11
      PT_BOTTOM: ovf_evt = tick && at_bottom && (phase_q == PHASE_DOWN); // R9 R12
      default: ovf_evt = tick && (count_q == COUNT_MAX); // R10
    endcase
    case (mode.reload)
      PT_TOP: reload_evt = tick && at_top; // R9 R11 R12
      PT_BOTTOM: reload_evt = tick && at_bottom; // R12
      default: reload_evt = ce_i; // R10
    endcase
  end

  // counter sequence per waveform kind
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_q <= VALUE16_RESET;
      phase_q <= PHASE_UP;
    end
    else if (tick)
    begin
      case (mode.kind)
        KIND_MATCH_CLR, KIND_FAST:
        begin
          count_q <= at_top ? COUNT_BOTTOM : count_q + COUNT_STEP; // R10 R11
          phase_q <= PHASE_UP;
        end
        KIND_DUAL:
        begin
          // turn at top and at bottom; each end value stands for one tick
          if (phase_q == PHASE_UP && at_top)
          begin
            count_q <= count_q - COUNT_STEP; // R15
            phase_q <= PHASE_DOWN;
          end
          else if (phase_q == PHASE_DOWN && at_bottom)
          begin
            count_q <= count_q + COUNT_STEP; // R15
            phase_q <= PHASE_UP;
          end
          else
          begin
            count_q <= (phase_q == PHASE_DOWN) ? count_q - COUNT_STEP : count_q + COUNT_STEP;
          end
        end
        default:
        begin
          count_q <= count_q + COUNT_STEP; // R10
          phase_q <= PHASE_UP;
        end
      endcase
    end
  end

  // compare double buffer; immediate modes copy every enabled cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < 3; i++)
        cmp_act_q[i] <= VALUE16_RESET;
    end
    else if (reload_evt)
    begin
      for (int i = 0; i < 3; i++)
        cmp_act_q[i] <= cmp_buf_q[i];
    end
  end

  // per-channel match and action fields
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      match[i] = tick && (count_q == cmp_act_q[i]);
  end
  assign action[0] = output_mode_ctrl_q[CHAN_A_ACTION_LSB +: 2];
  assign action[1] = output_mode_ctrl_q[CHAN_B_ACTION_LSB +: 2];
  assign action[2] = output_mode_ctrl_q[CHAN_C_ACTION_LSB +: 2];

  // one waveform unit per channel; only channel A may toggle in PWM modes
  for (genvar g = 0; g < 3; g++)
  begin : g_chan
    compare_channel #(
      .CHAN_IS_A(g == 0)
    ) u_chan (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .tick_i(tick),
      .kind_i(mode.kind),
      .action_i(action[g]),
      .wave_mode_msb_i(wave_mode_select[3]),
      .match_i(match[g]),
      .at_top_i(at_top),
      .phase_down_i(phase_q == PHASE_DOWN),
      .wave_o(wave[g]),
      .pin_take_o(pin_take[g])
    );
  end

  // pin direction is software's job; these only say who owns the pin value
  assign compare_out_a_o = wave[0]; // R2
  assign compare_out_b_o = wave[1];
  assign compare_out_c_o = wave[2];
  assign pin_override_a_o = pin_take[0];
  assign pin_override_b_o = pin_take[1];
  assign pin_override_c_o = pin_take[2];

  // write channel: address and data latched independently, either order
  assign do_write = ce_i && aw_held_q && w_held_q && !bvalid_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid_i && awready_q)
      begin
        awaddr_q <= s_axi_awaddr_i;
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q)
      begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready_i)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // control, compare and capture registers written by software
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      output_mode_ctrl_q <= OUTPUT_MODE_CTRL_RESET;
      timer_control_b_q <= CONTROL_B_RESET;
      capture_value_q <= VALUE16_RESET;
      for (int i = 0; i < 3; i++)
        cmp_buf_q[i] <= VALUE16_RESET;
    end
    else if (do_write)
    begin
      if (addr_is(awaddr_q, ADDR_OUTPUT_MODE_CTRL) && wstrb_q[0])
        output_mode_ctrl_q <= wdata_q[7:0];
      if (addr_is(awaddr_q, ADDR_TIMER_CONTROL_B) && wstrb_q[0])
        timer_control_b_q <= wdata_q[7:0] & CONTROL_B_MASK; // R14
      if (addr_is(awaddr_q, ADDR_CAPTURE))
        capture_value_q <= merge16(capture_value_q, wdata_q, wstrb_q);
      if (addr_is(awaddr_q, ADDR_COMPARE_A))
        cmp_buf_q[0] <= merge16(cmp_buf_q[0], wdata_q, wstrb_q);
      if (addr_is(awaddr_q, ADDR_COMPARE_B))
        cmp_buf_q[1] <= merge16(cmp_buf_q[1], wdata_q, wstrb_q);
      if (addr_is(awaddr_q, ADDR_COMPARE_C))
        cmp_buf_q[2] <= merge16(cmp_buf_q[2], wdata_q, wstrb_q);
    end
  end

  // sticky status: a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (do_write && addr_is(awaddr_q, ADDR_IRQ_MASK) && wstrb_q[0])
        irq_mask_q <= wdata_q[IRQ_WIDTH-1:0];
      irq_status_q <= (irq_status_q &
                       ~((do_write && addr_is(awaddr_q, ADDR_IRQ_STATUS) && wstrb_q[0]) ?
                         wdata_q[IRQ_WIDTH-1:0] : '0)) |
                      {match, ovf_evt};
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_arvalid_i && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= 32'h0000_0000;
        if (addr_is(s_axi_araddr_i, ADDR_OUTPUT_MODE_CTRL))
          rdata_q[7:0] <= output_mode_ctrl_q;
        if (addr_is(s_axi_araddr_i, ADDR_TIMER_CONTROL_B))
          rdata_q[7:0] <= timer_control_b_q;
        if (addr_is(s_axi_araddr_i, ADDR_COMPARE_A))
          rdata_q[15:0] <= cmp_buf_q[0];
        if (addr_is(s_axi_araddr_i, ADDR_COMPARE_B))
          rdata_q[15:0] <= cmp_buf_q[1];
        if (addr_is(s_axi_araddr_i, ADDR_COMPARE_C))
          rdata_q[15:0] <= cmp_buf_q[2];
        if (addr_is(s_axi_araddr_i, ADDR_CAPTURE))
          rdata_q[15:0] <= capture_value_q;
        if (addr_is(s_axi_araddr_i, ADDR_COUNTER))
          rdata_q[15:0] <= count_q;
        if (addr_is(s_axi_araddr_i, ADDR_IRQ_STATUS))
          rdata_q[IRQ_WIDTH-1:0] <= irq_status_q;
        if (addr_is(s_axi_araddr_i, ADDR_IRQ_MASK))
          rdata_q[IRQ_WIDTH-1:0] <= irq_mask_q;
      end
      else if (rvalid_q && s_axi_rready_i)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign irq_o = irq_q;

  // checks on the pin takeover, waveform and counter behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_fast_top_tick;
    tick && mode.kind == KIND_FAST && at_top;
  endsequence
  sequence s_dual_turn_up;
    tick && mode.kind == KIND_DUAL && phase_q == PHASE_UP && at_top;
  endsequence

  property p_pin_take;
    ce_i && action[0] == 2'h2 |=> pin_override_a_o;
  endproperty
  a_pin_take: assert property (p_pin_take) else $error("pin not taken over"); // R1

  property p_nonpwm_clear;
    match[1] && action[1] == 2'h2 &&
      (mode.kind == KIND_NORMAL || mode.kind == KIND_MATCH_CLR) |=> !compare_out_b_o;
  endproperty
  a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("no clear on match"); // R3

  property p_fast_set_top;
    s_fast_top_tick and action[0] == 2'h2 |=> compare_out_a_o;
  endproperty
  a_fast_set_top: assert property (p_fast_set_top) else $error("no set at top"); // R4

  property p_pwm_b_disc;
    ce_i && mode.kind == KIND_DUAL && action[1] == 2'h1 |=> !pin_override_b_o;
  endproperty
  a_pwm_b_disc: assert property (p_pwm_b_disc) else $error("reserved code took pin"); // R5

  property p_fast_top_wins;
    s_fast_top_tick and match[2] && action[2] == 2'h3 |=> !compare_out_c_o;
  endproperty
  a_fast_top_wins: assert property (p_fast_top_wins) else $error("match at top won"); // R6

  property p_dual_down_set;
    match[0] && mode.kind == KIND_DUAL && phase_q == PHASE_DOWN && action[0] == 2'h2
      |=> compare_out_a_o;
  endproperty
  a_dual_down_set: assert property (p_dual_down_set) else $error("no set on down"); // R7

  property p_mode15_top;
    wave_mode_select == 4'hF |-> top_val == cmp_act_q[0];
  endproperty
  a_mode15_top: assert property (p_mode15_top) else $error("wrong top source"); // R8

  property p_mode1_ovf;
    wave_mode_select == 4'h1 && tick && at_bottom && phase_q == PHASE_DOWN
      |=> irq_status_q[IRQ_OVERFLOW_BIT];
  endproperty
  a_mode1_ovf: assert property (p_mode1_ovf) else $error("no overflow at bottom"); // R9

  property p_match_wrap;
    tick && mode.kind == KIND_MATCH_CLR && at_top |=> count_q == COUNT_BOTTOM;
  endproperty
  a_match_wrap: assert property (p_match_wrap) else $error("no wrap at top"); // R10

  property p_mode5_top;
    wave_mode_select == 4'h5 |-> top_val == 16'h00FF;
  endproperty
  a_mode5_top: assert property (p_mode5_top) else $error("wrong fast top"); // R11

  property p_dual_turn;
    s_dual_turn_up |=> phase_q == PHASE_DOWN && count_q == $past(count_q) - COUNT_STEP;
  endproperty
  a_dual_turn: assert property (p_dual_turn) else $error("no turn at top"); // R15

endmodule : timer_wave_mode_output_control

//--- design/timer_wave_pkg.sv
package timer_wave_pkg;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_OUTPUT_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMER_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE_C = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_COUNTER = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // field positions
  localparam int CHAN_A_ACTION_LSB = 6;
  localparam int CHAN_B_ACTION_LSB = 4;
  localparam int CHAN_C_ACTION_LSB = 2;
  localparam int WAVE_MODE_LOW_LSB = 0;
  localparam int WAVE_MODE_HIGH_LSB = 3;
  localparam int COUNT_RUN_BIT = 0;
  localparam logic [7:0] CONTROL_B_MASK = 8'h19;
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_MATCH_LSB = 1;
  localparam int IRQ_WIDTH = 4;

  // values after reset
  localparam logic [7:0] OUTPUT_MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [15:0] VALUE16_RESET = 16'h0000;

  // counter landmarks
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    KIND_NORMAL = 4'h1,
    KIND_MATCH_CLR = 4'h2,
    KIND_FAST = 4'h4,
    KIND_DUAL = 4'h8
  } kind_t;

  typedef enum logic [2:0] {
    TOP_FIXED = 3'h1,
    TOP_CMP_A = 3'h2,
    TOP_CAPTURE = 3'h4
  } top_src_t;

  typedef enum logic [3:0] {
    PT_IMMEDIATE = 4'h1,
    PT_MAX = 4'h2,
    PT_TOP = 4'h4,
    PT_BOTTOM = 4'h8
  } point_t;

  typedef enum logic [1:0] {
    PHASE_UP = 2'h1,
    PHASE_DOWN = 2'h2
  } phase_t;

  typedef struct packed {
    kind_t kind;
    top_src_t top_src;
    logic [15:0] fixed_top;
    point_t reload;
    point_t ovf;
  } mode_info_t;

  // wave_mode_select decode; the reserved code falls back to normal counting
  function automatic mode_info_t decode_mode(input logic [3:0] m);
    mode_info_t r;
    r = '{KIND_NORMAL, TOP_FIXED, COUNT_MAX, PT_IMMEDIATE, PT_MAX};
    case (m)
      4'h1: r = '{KIND_DUAL, TOP_FIXED, TOP_8BIT, PT_TOP, PT_BOTTOM};
      4'h2: r = '{KIND_DUAL, TOP_FIXED, TOP_9BIT, PT_TOP, PT_BOTTOM};
      4'h3: r = '{KIND_DUAL, TOP_FIXED, TOP_10BIT, PT_TOP, PT_BOTTOM};
      4'h4: r = '{KIND_MATCH_CLR, TOP_CMP_A, COUNT_MAX, PT_IMMEDIATE, PT_MAX};
      4'h5: r = '{KIND_FAST, TOP_FIXED, TOP_8BIT, PT_TOP, PT_TOP};
      4'h6: r = '{KIND_FAST, TOP_FIXED, TOP_9BIT, PT_TOP, PT_TOP};
      4'h7: r = '{KIND_FAST, TOP_FIXED, TOP_10BIT, PT_TOP, PT_TOP};
      4'h8: r = '{KIND_DUAL, TOP_CAPTURE, COUNT_MAX, PT_BOTTOM, PT_BOTTOM};
      4'h9: r = '{KIND_DUAL, TOP_CMP_A, COUNT_MAX, PT_BOTTOM, PT_BOTTOM};
      4'hA: r = '{KIND_DUAL, TOP_CAPTURE, COUNT_MAX, PT_TOP, PT_BOTTOM};
      4'hB: r = '{KIND_DUAL, TOP_CMP_A, COUNT_MAX, PT_TOP, PT_BOTTOM};
      4'hC: r = '{KIND_MATCH_CLR, TOP_CAPTURE, COUNT_MAX, PT_IMMEDIATE, PT_MAX};
      4'hE: r = '{KIND_FAST, TOP_CAPTURE, COUNT_MAX, PT_TOP, PT_TOP};
      4'hF: r = '{KIND_FAST, TOP_CMP_A, COUNT_MAX, PT_TOP, PT_TOP};
      default: r = '{KIND_NORMAL, TOP_FIXED, COUNT_MAX, PT_IMMEDIATE, PT_MAX};
    endcase
    return r;
  endfunction : decode_mode

endpackage : timer_wave_pkg

//--- dv/port_pin_model.sv
module port_pin_model (
  // pin drivers
  input wire logic override_i,
  input wire logic wave_i,
  input wire logic port_i,
  input wire logic dir_out_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // driver off leaves the pull-up level, never the last wave value
  assign pin_o = !dir_out_i ? 1'b1 : (override_i ? wave_i : port_i);
endmodule : port_pin_model

//--- dv/tb_top.sv
module tb_top
  import timer_wave_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, ce = 1'b1, dir_a = 1'b1, port_a = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] ws = 4'hF;
  logic awr, wrd, bv, arr, rv, irq, oa, ob, oc, pa, pb, pc, pin_a;
  logic [1:0] br, rr, r2, act;
  logic [31:0] rd, d;
  int err_count = 0, n_checks = 0, cyc = 0, t0, m, c, n, t;
  int ml[8] = '{1, 2, 3, 5, 6, 7, 8, 4};
  timer_wave_mode_output_control i_timer_wave_mode_output_control (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .compare_out_a_o(oa), .compare_out_b_o(ob), .compare_out_c_o(oc),
    .pin_override_a_o(pa), .pin_override_b_o(pb), .pin_override_c_o(pc), .irq_o(irq));
  port_pin_model i_port_pin_model (.override_i(pa), .wave_i(oa), .port_i(port_a),
    .dir_out_i(dir_a), .pin_o(pin_a));
  // clock
  initial
  begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // blocking count so edge-timed waits read it already updated
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc > 60000)
    begin
      err_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    forever
    begin
      @(posedge clk_sys_i);
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wrd)
        wv <= 1'b0;
      if (bv)
        break;
    end
    r2 = br;
    bry <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a);
    @(posedge clk_sys_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    forever
    begin
      @(posedge clk_sys_i);
      if (arv && arr)
        arv <= 1'b0;
      if (rv)
        break;
    end
    d = rd;
    r2 = rr;
    rry <= 1'b0;
  endtask : rdc
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // main sequence
  initial
  begin
    void'($urandom(32'h97711517));
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rdc(ADDR_OUTPUT_MODE_CTRL);
    chk("ctrl_reset", {24'h000000, OUTPUT_MODE_CTRL_RESET}, d);
    rdc(8'h24);
    chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, r2});
    wr(8'h24, 32'hFFFFFFFF);
    chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, r2});
    n = $urandom & 255;
    wr(ADDR_OUTPUT_MODE_CTRL, n);
    rdc(ADDR_OUTPUT_MODE_CTRL);
    chk("ctrl_rw", n, d);
    $display("bus test done");
    // takeover for every action code in normal mode
    for (c = 0; c < 4; c++)
    begin
      wr(ADDR_OUTPUT_MODE_CTRL, {24'h000000, c[1:0], c[1:0], c[1:0], 2'b00});
      repeat (2) @(posedge clk_sys_i);
      chk("override", {29'h0, {3{c != 0}}}, {29'h0, pa, pb, pc});
    end
    wr(ADDR_TIMER_CONTROL_B, 32'h000000FF);
    rdc(ADDR_TIMER_CONTROL_B);
    chk("ctrl_b", {24'h000000, CONTROL_B_MASK}, d);
    // waveform period per mode; compare A random, below every fixed top
    for (c = 0; c < 8; c++)
    begin
      m = ml[c];
      n = 16 + ($urandom & 63);
      t = (1 << (8 + (m - 1) % 4)) - 1;
      act = (m == 4) ? 2'b01 : {1'b1, c[0]};
      // reset per mode: the counter cannot overshoot a lower top, and mode 13 is never passed
      @(posedge clk_sys_i);
      reset_n_i <= 1'b0;
      @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      wr(ADDR_COMPARE_A, n);
      wr(ADDR_COMPARE_C, t);
      wr(ADDR_CAPTURE, t);
      wr(ADDR_OUTPUT_MODE_CTRL, {24'h0, act, 2'b10, act, m[1:0]});
      wr(ADDR_TIMER_CONTROL_B, {27'h0, m[3:2], 3'b001});
      // expected period: toggle every n+1, dual-slope twice top, fast top+1
      t = (m == 4) ? 2 * (n + 1) : (m < 4 || m == 8) ? 2 * t : t + 1;
      @(posedge oa);
      @(posedge oa);
      t0 = cyc;
      @(posedge oa);
      chk("period", t, cyc - t0);
      // pin model follows oa combinationally, so look once it has settled
      @(negedge clk_sys_i);
      chk("pin", {31'h0, oa}, {31'h0, pin_a});
      if (m > 4 && m < 8)
        chk("chan_c_top", {31'h0, ~c[0]}, {31'h0, oc});
    end
    $display("mode test done");
    // overflow interrupt, masked then unmasked, then cleared
    wr(ADDR_OUTPUT_MODE_CTRL, 32'h00000081);
    wr(ADDR_TIMER_CONTROL_B, 32'h00000009);
    wr(ADDR_IRQ_MASK, 32'h00000000);
    wr(ADDR_IRQ_STATUS, 32'h0000000F);
    repeat (300) @(posedge clk_sys_i);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc(ADDR_IRQ_STATUS);
    chk("ovf_flag", 32'h1, {31'h0, d[IRQ_OVERFLOW_BIT]});
    wr(ADDR_IRQ_MASK, 32'h00000001);
    repeat (3) @(posedge clk_sys_i);
    chk("irq_on", 32'h1, {31'h0, irq});
    // enable low freezes the counter; only the ticks at the two reads advance it
    rdc(ADDR_COUNTER);
    t0 = d;
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    ce <= 1'b1;
    rdc(ADDR_COUNTER);
    chk("ce_freeze", 32'h3, (d - t0) & 32'hFF);
    wr(ADDR_TIMER_CONTROL_B, 32'h00000000);
    wr(ADDR_IRQ_STATUS, 32'h00000001);
    repeat (3) @(posedge clk_sys_i);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("irq test done");
    // code 01 in pwm: disconnected unless mode msb, then channel A only
    wr(ADDR_OUTPUT_MODE_CTRL, 32'h00000057);
    repeat (2) @(posedge clk_sys_i);
    chk("code01_msb0", 32'h0, {29'h0, pa, pb, pc});
    wr(ADDR_TIMER_CONTROL_B, 32'h00000018);
    repeat (2) @(posedge clk_sys_i);
    chk("code01_msb1", 32'h4, {29'h0, pa, pb, pc});
    $display("code test done");
    results();
  end
endmodule : tb_top
